// ==== psb_pkg.sv ====
// Function
// - temperature status bit 0 reads 1 while die is above hot threshold, else 0.
// - temperature status at 04h, resets to zero, bits 7 to 1 read zero.
// - shutdown cause at 05h, resets to zero, bits 7 to 4 read zero.
// - cause flags are set by hardware only; host writes 1 to clear, 0 keeps.
// - bit 2 is set on a shutdown caused by supply undervoltage.
// - bit 1 is set on a shutdown caused by an unmasked rail fault.
// - bit 0 is set on a shutdown caused by critical die temperature.
// - any of those three cause flags becoming set also sets shutdown irq flag.
// - cold-off flag bit 3 is never set by hardware; writing 1 clears it.
// - per-rail fault status is readable at B2h and B3h.
// - controller 1 register at 20h, factory reset, bits 7 to 1 voltage code.
// - controller 2 register at 21h, factory reset, bits 7 to 1 voltage code.
// - voltage codes map onto 10 mV step and 25 mV step ranges.
// - bit 0 picks active ramp down (0) or passive decay (1).
// - shutdown irq flag is bit 3 at 02h, set on shutdown, write 1 clears only while all cause flags are zero.
package psb_pkg;
  // register offsets
  localparam logic [7:0] ADDR_IRQ = 8'h02;
  localparam logic [7:0] ADDR_TEMP = 8'h04;
  localparam logic [7:0] ADDR_CAUSE = 8'h05;
  localparam logic [7:0] ADDR_CTRL1 = 8'h20;
  localparam logic [7:0] ADDR_CTRL2 = 8'h21;
  localparam logic [7:0] ADDR_FAULT1 = 8'hb2;
  localparam logic [7:0] ADDR_FAULT2 = 8'hb3;
  // field positions
  localparam int HOT_BIT = 0;
  localparam int CAUSE_COLD_BIT = 3;
  localparam int CAUSE_UV_BIT = 2;
  localparam int CAUSE_RAIL_BIT = 1;
  localparam int CAUSE_HEAT_BIT = 0;
  localparam int IRQ_SHUT_BIT = 3;
  localparam int CTRL_DECAY_BIT = 0;
  localparam int CTRL_CODE_LSB = 1;
  localparam int CTRL_CODE_MSB = 7;
  // reset values
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [3:0] CAUSE_RESET = 4'h0;
  localparam logic IRQ_RESET = 1'b0;
  localparam logic [7:0] CTRL_FACTORY_DEFAULT = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // serial port; slave address value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5e;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  // voltage lookup defaults
  localparam logic [15:0] VC_FINE_STEP_MV = 16'h000a;
  localparam logic [15:0] VC_COARSE_STEP_MV = 16'h0019;
  localparam logic [6:0] VC_SPLIT_DEFAULT = 7'h40;
  localparam logic [15:0] VC_FINE_BASE_DEFAULT = 16'h0000;
  localparam logic [15:0] VC_COARSE_BASE_DEFAULT = 16'h0000;
  // synchroniser lane layout
  localparam int SYNC_W = 22;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_HOT = 2;
  localparam int SY_UV = 3;
  localparam int SY_RAIL = 4;
  localparam int SY_HEAT = 5;
  localparam int SY_FAULT_LSB = 6;
  localparam int SY_FAULT_MSB = 21;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } psb_state_t;
endpackage

// ==== psb_sync.sv ====
`timescale 1ns/100ps
module psb_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // psb_sync

// ==== psb_vcode_lut.sv ====
`timescale 1ns/100ps
module psb_vcode_lut import psb_pkg::*; #(
  parameter logic [6:0] SPLIT_CODE = VC_SPLIT_DEFAULT,
  parameter logic [15:0] FINE_BASE_MV = VC_FINE_BASE_DEFAULT,
  parameter logic [15:0] COARSE_BASE_MV = VC_COARSE_BASE_DEFAULT
) (
  input wire logic [6:0] code,
  output logic [15:0] target_mv
);
  logic [15:0] code_w;
  logic [15:0] split_w;

  assign code_w = {9'h000, code};
  assign split_w = {9'h000, SPLIT_CODE};

  // fine range below split, coarse range from split upward
  always_comb begin
    if (code < SPLIT_CODE) begin
      target_mv = 16'(FINE_BASE_MV + code_w * VC_FINE_STEP_MV);
    end else begin
      target_mv = 16'(COARSE_BASE_MV +
                      (code_w - split_w) * VC_COARSE_STEP_MV);
    end
  end
endmodule // psb_vcode_lut

// ==== psb_regs.sv ====
`timescale 1ns/100ps
module psb_regs import psb_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter logic [7:0] CTRL1_FACTORY = CTRL_FACTORY_DEFAULT,
  parameter logic [7:0] CTRL2_FACTORY = CTRL_FACTORY_DEFAULT,
  parameter logic [6:0] SPLIT_CODE = VC_SPLIT_DEFAULT,
  parameter logic [15:0] FINE_BASE_MV = VC_FINE_BASE_DEFAULT,
  parameter logic [15:0] COARSE_BASE_MV = VC_COARSE_BASE_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic die_above_hot,
  input wire logic uv_shutdown,
  input wire logic rail_fault_shutdown,
  input wire logic overheat_shutdown,
  input wire logic [15:0] rail_fault_status,
  output logic shutdown_irq_flag,
  output logic [6:0] ctrl1_voltage_code,
  output logic ctrl1_passive_ramp_sel,
  output logic [6:0] ctrl2_voltage_code,
  output logic ctrl2_passive_ramp_sel,
  output logic [15:0] ctrl1_target_mv,
  output logic [15:0] ctrl2_target_mv
);
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic scl_s;
  logic sda_s;
  logic hot_s;
  logic [15:0] fault_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  psb_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic mack_reg;
  logic sda_oe_reg;
  logic sda_out_reg;
  logic wr_pulse_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] rd_byte;

  logic [2:0] evt_prev_reg;
  logic [3:0] cause_set;
  logic [3:0] cause_clr;
  logic [3:0] cause_reg;
  logic [3:0] cause_next;
  logic irq_reg;
  logic irq_next;
  logic irq_set;
  logic irq_clr;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [15:0] lut1_mv;
  logic [15:0] lut2_mv;
  logic [15:0] tgt1_reg;
  logic [15:0] tgt2_reg;

  // true in the cycle a host write to the given offset completes
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wr_pulse_reg && (wr_addr_reg == a);
  endfunction

  // every pin input passes two flops
  always_comb begin
    raw_in = '0;
    raw_in[SY_SCL] = scl_in;
    raw_in[SY_SDA] = sda_in;
    raw_in[SY_HOT] = die_above_hot;
    raw_in[SY_UV] = uv_shutdown;
    raw_in[SY_RAIL] = rail_fault_shutdown;
    raw_in[SY_HEAT] = overheat_shutdown;
    raw_in[SY_FAULT_MSB:SY_FAULT_LSB] = rail_fault_status;
  end

  psb_sync #(
    .W(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign scl_s = sync_in[SY_SCL];
  assign sda_s = sync_in[SY_SDA];
  assign hot_s = sync_in[SY_HOT];
  assign fault_s = sync_in[SY_FAULT_MSB:SY_FAULT_LSB];

  // bus line edges and start/stop conditions
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_prev_reg <= 1'b0;
      sda_prev_reg <= 1'b0;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // read data for the current pointer
  always_comb begin
    case (ptr_reg)
      ADDR_IRQ: rd_byte = {4'h0, irq_reg, 3'h0};
      ADDR_TEMP: rd_byte = {7'h00, hot_s};
      ADDR_CAUSE: rd_byte = {4'h0, cause_reg};
      ADDR_CTRL1: rd_byte = ctrl1_reg;
      ADDR_CTRL2: rd_byte = ctrl2_reg;
      ADDR_FAULT1: rd_byte = fault_s[7:0];
      ADDR_FAULT2: rd_byte = fault_s[15:8];
      default: rd_byte = READ_ZERO;
    endcase
  end

  // serial slave: address, register pointer, then data bytes
  always_ff @(posedge ref_clk) begin
    wr_pulse_reg <= 1'b0;
    sda_out_reg <= 1'b0;
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                state_reg <= ST_ACK_ADDR;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (state_reg == ST_PTR) begin
              ptr_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg <= ST_ACK_PTR;
            end else begin
              wr_pulse_reg <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg <= ptr_reg + 8'h01;
              sda_oe_reg <= 1'b1;
              state_reg <= ST_ACK_WR;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RD;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_PTR;
            end
          end
        end
        ST_ACK_PTR, ST_ACK_WR: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt_reg == LAST_TX_BIT) begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_ACK_RD;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
        end
        ST_ACK_RD: begin
          if (scl_rise) begin
            mack_reg <= ~sda_s;
          end else if (scl_fall) begin
            if (mack_reg) begin
              tx_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RD;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // shutdown events: rising edge of each synchronised request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      evt_prev_reg <= 3'h0;
    end else begin
      evt_prev_reg <= {sync_in[SY_UV], sync_in[SY_RAIL], sync_in[SY_HEAT]};
    end
  end

  always_comb begin
    cause_set = 4'h0;
    cause_set[CAUSE_COLD_BIT] = 1'b0;
    cause_set[CAUSE_UV_BIT] = sync_in[SY_UV] & ~evt_prev_reg[2];
    cause_set[CAUSE_RAIL_BIT] = sync_in[SY_RAIL] & ~evt_prev_reg[1];
    cause_set[CAUSE_HEAT_BIT] = sync_in[SY_HEAT] & ~evt_prev_reg[0];
    cause_clr = wr_hit(ADDR_CAUSE) ? wr_data_reg[3:0] : 4'h0;
    // a new event wins over a clear in the same cycle
    cause_next = (cause_reg & ~cause_clr) | cause_set;
    irq_set = |cause_set;
    irq_clr = wr_hit(ADDR_IRQ) && wr_data_reg[IRQ_SHUT_BIT] &&
              (cause_reg == 4'h0);
    irq_next = irq_set | (irq_reg & ~irq_clr);
  end

  // reset or a host write of 1 clears the cause flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cause_reg <= CAUSE_RESET;
      irq_reg <= IRQ_RESET;
    end else begin
      cause_reg <= cause_next;
      irq_reg <= irq_next;
    end
  end

  // controller voltage registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl1_reg <= CTRL1_FACTORY;
      ctrl2_reg <= CTRL2_FACTORY;
    end else begin
      if (wr_hit(ADDR_CTRL1)) begin
        ctrl1_reg <= wr_data_reg;
      end
      if (wr_hit(ADDR_CTRL2)) begin
        ctrl2_reg <= wr_data_reg;
      end
    end
  end

  psb_vcode_lut #(
    .SPLIT_CODE(SPLIT_CODE),
    .FINE_BASE_MV(FINE_BASE_MV),
    .COARSE_BASE_MV(COARSE_BASE_MV)
  ) u_lut1 (
    .code(ctrl1_reg[CTRL_CODE_MSB:CTRL_CODE_LSB]),
    .target_mv(lut1_mv)
  );

  psb_vcode_lut #(
    .SPLIT_CODE(SPLIT_CODE),
    .FINE_BASE_MV(FINE_BASE_MV),
    .COARSE_BASE_MV(COARSE_BASE_MV)
  ) u_lut2 (
    .code(ctrl2_reg[CTRL_CODE_MSB:CTRL_CODE_LSB]),
    .target_mv(lut2_mv)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tgt1_reg <= 16'h0000;
      tgt2_reg <= 16'h0000;
    end else begin
      tgt1_reg <= lut1_mv;
      tgt2_reg <= lut2_mv;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign shutdown_irq_flag = irq_reg;
  assign ctrl1_voltage_code = ctrl1_reg[CTRL_CODE_MSB:CTRL_CODE_LSB];
  assign ctrl1_passive_ramp_sel = ctrl1_reg[CTRL_DECAY_BIT];
  assign ctrl2_voltage_code = ctrl2_reg[CTRL_CODE_MSB:CTRL_CODE_LSB];
  assign ctrl2_passive_ramp_sel = ctrl2_reg[CTRL_DECAY_BIT];
  assign ctrl1_target_mv = tgt1_reg;
  assign ctrl2_target_mv = tgt2_reg;
endmodule // psb_regs

// ==== psb_regs_properties.sv ====
`timescale 1ns/100ps
module psb_regs_properties import psb_pkg::*; #(
  parameter logic [7:0] CTRL1_FACTORY = CTRL_FACTORY_DEFAULT,
  parameter logic [6:0] SPLIT_CODE = VC_SPLIT_DEFAULT,
  parameter logic [15:0] FINE_BASE_MV = VC_FINE_BASE_DEFAULT,
  parameter logic [15:0] COARSE_BASE_MV = VC_COARSE_BASE_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic uv_shutdown,
  input wire logic rail_fault_shutdown,
  input wire logic overheat_shutdown,
  input wire logic shutdown_irq_flag,
  input wire logic [6:0] ctrl1_voltage_code,
  input wire logic ctrl1_passive_ramp_sel,
  input wire logic [6:0] ctrl2_voltage_code,
  input wire logic ctrl2_passive_ramp_sel,
  input wire logic [15:0] ctrl1_target_mv,
  input wire logic [15:0] ctrl2_target_mv
);
  logic [2:0] ev_prev;
  logic [3:0] ev_age;
  wire logic [2:0] ev_now;
  assign ev_now = {uv_shutdown, rail_fault_shutdown, overheat_shutdown};
  function automatic logic [15:0] mv(input logic [6:0] c);
    if (c < SPLIT_CODE) return FINE_BASE_MV + c * VC_FINE_STEP_MV;
    return COARSE_BASE_MV + (c - SPLIT_CODE) * VC_COARSE_STEP_MV;
  endfunction
  // cycles since the last rising shutdown input
  always_ff @(posedge ref_clk) begin
    ev_prev <= ev_now;
    if (sys_rst) ev_age <= 4'hf;
    else if (|(ev_now & ~ev_prev)) ev_age <= 4'h0;
    else if (ev_age != 4'hf) ev_age <= ev_age + 4'h1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  a_reset_vals: assert property (
    $fell(sys_rst) |-> !sda_oe && !shutdown_irq_flag &&
    ctrl1_voltage_code == CTRL1_FACTORY[7:1])
    else $error("outputs wrong after reset");
  a_irq_uv: assert property (
    $rose(uv_shutdown) |-> ##5 shutdown_irq_flag [*8])
    else $error("irq not set by undervoltage");
  a_irq_rail: assert property (
    $rose(rail_fault_shutdown) |-> ##5 shutdown_irq_flag [*8])
    else $error("irq not set by rail fault");
  a_irq_heat: assert property (
    $rose(overheat_shutdown) |-> ##5 shutdown_irq_flag [*8])
    else $error("irq not set by overheat");
  a_irq_cause: assert property (
    $rose(shutdown_irq_flag) |-> ev_age <= 4'h6)
    else $error("irq set without shutdown");
  a_ctrl1_lut: assert property (
    !$past(sys_rst) |-> ctrl1_target_mv == mv($past(ctrl1_voltage_code)))
    else $error("ctrl1 target wrong");
  a_ctrl2_lut: assert property (
    !$past(sys_rst) |-> ctrl2_target_mv == mv($past(ctrl2_voltage_code)))
    else $error("ctrl2 target wrong");
  a_ctrl_by_bus: assert property (
    $changed({ctrl1_voltage_code, ctrl1_passive_ramp_sel,
    ctrl2_voltage_code, ctrl2_passive_ramp_sel}) |-> !scl_in)
    else $error("ctrl changed outside a bus write");
  a_sda_scl_low: assert property (
    $changed(sda_oe) |-> !scl_in)
    else $error("sda moved while scl high");
  cover property ($rose(shutdown_irq_flag));
  cover property ($fell(shutdown_irq_flag));
  cover property ($rose(sda_oe));
  cover property ($changed(ctrl2_voltage_code));
endmodule // psb_regs_properties
bind psb_regs psb_regs_properties #(.CTRL1_FACTORY(CTRL1_FACTORY),
  .SPLIT_CODE(SPLIT_CODE), .FINE_BASE_MV(FINE_BASE_MV),
  .COARSE_BASE_MV(COARSE_BASE_MV)) i_props (.ref_clk, .sys_rst, .scl_in,
  .sda_oe, .uv_shutdown, .rail_fault_shutdown, .overheat_shutdown,
  .shutdown_irq_flag, .ctrl1_voltage_code, .ctrl1_passive_ramp_sel,
  .ctrl2_voltage_code, .ctrl2_passive_ramp_sel, .ctrl1_target_mv,
  .ctrl2_target_mv);

// ==== psb_host_model.sv ====
`timescale 1ns/100ps
module psb_host_model import psb_pkg::*; (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_pull
);
  initial begin
    scl_drv = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic start_cond();
    sda_pull = 1'b0;
    tick(5);
    scl_drv = 1'b1;
    tick(5);
    sda_pull = 1'b1;
    tick(5);
    scl_drv = 1'b0;
    tick(5);
  endtask
  task automatic stop_cond();
    sda_pull = 1'b1;
    tick(5);
    scl_drv = 1'b1;
    tick(5);
    sda_pull = 1'b0;
    tick(5);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    tick(5);
    scl_drv = 1'b1;
    tick(5);
    r = sda_line;
    scl_drv = 1'b0;
    tick(2);
  endtask
  // master releases the ninth bit: ack sampled on writes, nack on reads
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic reg_wr(input logic [6:0] dev, input logic [7:0] a,
    input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start_cond();
    byte_io({dev, 1'b0}, q, k0);
    byte_io(a, q, k1);
    byte_io(d, q, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic k;
    start_cond();
    byte_io({DEV_ADDR_DEFAULT, 1'b0}, q, k);
    byte_io(a, q, k);
    start_cond();
    byte_io({DEV_ADDR_DEFAULT, 1'b1}, q, k);
    byte_io(8'hff, d, k);
    stop_cond();
  endtask
endmodule // psb_host_model

// ==== pmic_status_shutdown_buck_regs_tb.sv ====
`timescale 1ns/100ps
module pmic_status_shutdown_buck_regs_tb import psb_pkg::*; ();
  localparam logic [7:0] F1 = 8'h96;
  localparam logic [7:0] F2 = 8'h3c;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl_in, sda_in, sda_pull, sda_out, sda_oe, ok;
  logic die_above_hot, uv_shutdown, rail_fault_shutdown, overheat_shutdown;
  logic [15:0] rail_fault_status, ctrl1_target_mv, ctrl2_target_mv;
  logic shutdown_irq_flag, ctrl1_passive_ramp_sel, ctrl2_passive_ramp_sel;
  logic [6:0] ctrl1_voltage_code, ctrl2_voltage_code;
  logic [2:0] ev;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  assign sda_in = ~(sda_oe | sda_pull);
  always #50 ref_clk = ~ref_clk;
  psb_regs #(.CTRL1_FACTORY(F1), .CTRL2_FACTORY(F2)) i_dut (.ref_clk,
    .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe, .die_above_hot,
    .uv_shutdown, .rail_fault_shutdown, .overheat_shutdown,
    .rail_fault_status, .shutdown_irq_flag, .ctrl1_voltage_code,
    .ctrl1_passive_ramp_sel, .ctrl2_voltage_code, .ctrl2_passive_ramp_sel,
    .ctrl1_target_mv, .ctrl2_target_mv);
  psb_host_model i_host (.ref_clk, .sda_line(sda_in), .scl_drv(scl_in),
    .sda_pull);
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
    input logic [7:0] exp);
    logic [7:0] d;
    i_host.reg_rd(a, d);
    check(what, 16'(d), 16'(exp));
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
    i_host.reg_wr(DEV_ADDR_DEFAULT, a, d, ok);
    check("write ack", 16'(ok), 16'h0001);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    {die_above_hot, uv_shutdown, rail_fault_shutdown} = 3'h0;
    overheat_shutdown = 1'b0;
    rail_fault_status = 16'h0000;
    i_host.tick(20);
    sys_rst = 1'b0;
    i_host.tick(6);
    rd_chk("temp", ADDR_TEMP, TEMP_RESET);
    rd_chk("cause", ADDR_CAUSE, 8'h00);
    rd_chk("irq", ADDR_IRQ, 8'h00);
    rd_chk("ctrl1", ADDR_CTRL1, F1);
    rd_chk("ctrl2", ADDR_CTRL2, F2);
    $display("test reset done");
    die_above_hot = 1'b1;
    rd_chk("hot", ADDR_TEMP, 8'h01);
    check("sda out", 16'(sda_out), 16'h0000);
    die_above_hot = 1'b0;
    rd_chk("cool", ADDR_TEMP, 8'h00);
    wr_ok(ADDR_TEMP, 8'hff);
    rd_chk("temp ro", ADDR_TEMP, 8'h00);
    $display("test status done");
    for (int i = 0; i < 3; i++) begin
      ev = 3'h1 << i;
      {uv_shutdown, rail_fault_shutdown, overheat_shutdown} = ev;
      i_host.tick(8);
      check("irq set", 16'(shutdown_irq_flag), 16'h0001);
      rd_chk("cause set", ADDR_CAUSE, 8'(ev));
      wr_ok(ADDR_IRQ, 8'h08);
      check("irq held", 16'(shutdown_irq_flag), 16'h0001);
      rd_chk("irq reg", ADDR_IRQ, 8'h08);
      wr_ok(ADDR_CAUSE, 8'hf0);
      rd_chk("cause kept", ADDR_CAUSE, 8'(ev));
      wr_ok(ADDR_CAUSE, 8'hff);
      rd_chk("cause clear", ADDR_CAUSE, 8'h00);
      wr_ok(ADDR_IRQ, 8'h08);
      check("irq clear", 16'(shutdown_irq_flag), 16'h0000);
      {uv_shutdown, rail_fault_shutdown, overheat_shutdown} = 3'h0;
    end
    $display("test shutdown done");
    wr_ok(ADDR_CTRL1, 8'h81);
    wr_ok(ADDR_CTRL2, 8'h7e);
    check("code1", 16'(ctrl1_voltage_code), 16'h0040);
    check("decay1", 16'(ctrl1_passive_ramp_sel), 16'h0001);
    check("code2", 16'(ctrl2_voltage_code), 16'h003f);
    check("decay2", 16'(ctrl2_passive_ramp_sel), 16'h0000);
    check("mv1", ctrl1_target_mv, VC_COARSE_BASE_DEFAULT);
    check("mv2", ctrl2_target_mv,
      VC_FINE_BASE_DEFAULT + 16'h003f * VC_FINE_STEP_MV);
    i_host.reg_wr(DEV_ADDR_DEFAULT ^ 7'h01, ADDR_CTRL1, 8'h00, ok);
    check("foreign addr", 16'(ok), 16'h0000);
    rd_chk("ctrl1 back", ADDR_CTRL1, 8'h81);
    rd_chk("ctrl2 back", ADDR_CTRL2, 8'h7e);
    $display("test control done");
    rail_fault_status = 16'h5aa5;
    rd_chk("fault1", ADDR_FAULT1, 8'ha5);
    rd_chk("fault2", ADDR_FAULT2, 8'h5a);
    $display("test fault status done");
    conclude();
  end
endmodule // pmic_status_shutdown_buck_regs_tb
